/* File: core/wdt_power_ctrl.sv */
/*
 * Supervision timer, reset-source flags and halt/stop power-down control.
 * Assumes the processor core presents each executed opcode for one cycle on
 * the decode port and obeys cpuClkEn, coreReset and the restart vector.
 * The oscillator output pin, reset pin and wake line come in asynchronously.
 */
// Local design decision: strobed register access.
`timescale 1ns/1ps
module wdt_power_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // External pins
   input wire logic oscillatorOutputPin,
   input wire logic resetPin_n,
   input wire logic portBLineZero,
   // Core decode port
   input wire wdt_pd_pkg::core_req_t coreReq,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // Core control
   output logic cpuClkEn,
   output logic coreReset,
   output logic vectorValid,
   output logic [15:0] vectorAddr,
   // Clock and power status
   output logic oscEnable,
   output logic clkDiv2,
   output logic clkDiv4,
   output logic clkDiv8,
   output logic haltActive,
   output logic stopActive
);

   wdt_pd_pkg::state_t st_ff;
   wdt_pd_pkg::state_t nxt_st;

   logic oscTick;
   logic wdtTick;
   logic pinReset;
   logic timeout;
   logic restartNow;
   logic haltOp;
   logic stopOp;
   logic [2:0] sel;
   logic [15:0] initValue;
   logic wrCountA;
   logic wrCountB;
   logic wrCtrl;
   logic wrStatus;
   logic countFrozen;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of events seen this cycle.

   // glitch filter
   // The filtered level only moves when two synchronised samples agree.
   assign oscTick = st_ff.oscS2 && st_ff.oscS3 && !st_ff.oscFilt;

   assign wdtTick = oscTick && (st_ff.prescale == wdt_pd_pkg::PRESCALE_LAST);

   assign pinReset = !st_ff.rstPinS2;

   assign haltOp = coreReq.valid && (coreReq.opcode == wdt_pd_pkg::OP_HALT);
   assign stopOp = coreReq.valid && (coreReq.opcode == wdt_pd_pkg::OP_STOP);
   assign restartNow = coreReq.valid && coreReq.wdtRestart;

   assign sel = st_ff.ctrl[wdt_pd_pkg::SEL_MSB:wdt_pd_pkg::SEL_LSB];
   // select to value
   // Each select step adds 8192 counts; the top select gives the full range.
   assign initValue = {sel, wdt_pd_pkg::SEL_STEP_LOW};

   assign countFrozen = !st_ff.wdtRun
                        || (st_ff.mode == wdt_pd_pkg::MODE_STOP)
                        || (st_ff.mode == wdt_pd_pkg::MODE_WAKE)
                        || ((st_ff.mode == wdt_pd_pkg::MODE_HALT)
                            && !st_ff.ctrl[wdt_pd_pkg::HALT_RUN_BIT]);

   assign timeout = wdtTick && !countFrozen && (st_ff.wdtCount == 16'h0000);

   assign wrCountA = regWrite && (regAddr == wdt_pd_pkg::COUNT_A_OFS);
   assign wrCountB = regWrite && (regAddr == wdt_pd_pkg::COUNT_B_OFS);
   assign wrCtrl = regWrite && (regAddr == wdt_pd_pkg::TIMER_CONTROL_HIGH_OFS);
   assign wrStatus = regWrite && (regAddr == wdt_pd_pkg::STATUS_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      nxt_st = st_ff;
      nxt_st.coreReset = 1'b0;
      nxt_st.vectorValid = 1'b0;

      // Two-flop synchronisers; first stages feed only the second stages.
      nxt_st.oscS1 = oscillatorOutputPin;
      nxt_st.oscS2 = st_ff.oscS1;
      nxt_st.oscS3 = st_ff.oscS2;
      nxt_st.rstPinS1 = resetPin_n;
      nxt_st.rstPinS2 = st_ff.rstPinS1;
      nxt_st.wakeS1 = portBLineZero;
      nxt_st.wakeS2 = st_ff.wakeS1;

      if (st_ff.oscS2 == st_ff.oscS3) begin
         nxt_st.oscFilt = st_ff.oscS2;
      end
      if (oscTick) begin
         nxt_st.divCnt = st_ff.divCnt + 3'd1;
         nxt_st.prescale = st_ff.prescale + 6'd1;
      end

      if (wdtTick && !countFrozen && (st_ff.wdtCount != 16'h0000)) begin
         nxt_st.wdtCount = st_ff.wdtCount - 16'd1;
      end
      // Software writes win over the decrement, as with the other timers.
      if (wrCountA) begin
         nxt_st.wdtCount[7:0] = regWdata;
      end
      if (wrCountB) begin
         nxt_st.wdtCount[15:8] = regWdata;
      end
      if (restartNow) begin
         nxt_st.wdtCount = initValue;
      end

      if (wrCtrl) begin
         nxt_st.ctrl = regWdata & wdt_pd_pkg::CTRL_WRITE_MASK;
      end

      // disable before first write or opcode
      // Only a status write that is the first register write or executed opcode after reset may switch the timer off; reads leave the window open.
      if (wrStatus && st_ff.firstWindow && !regWdata[wdt_pd_pkg::WDT_RUN_BIT]) begin
         nxt_st.wdtRun = 1'b0;
      end
      if (coreReq.valid || regWrite) begin
         nxt_st.firstWindow = 1'b0;
      end

      if (wrStatus && !regWdata[wdt_pd_pkg::WDT_FLAG_BIT]) begin
         nxt_st.wdtFlag = 1'b0;
      end
      if (wrStatus && !regWdata[wdt_pd_pkg::STOP_FLAG_BIT]) begin
         nxt_st.stopFlag = 1'b0;
      end

      unique case (st_ff.mode)
         wdt_pd_pkg::MODE_RUN: begin
            if (haltOp) begin
               nxt_st.mode = wdt_pd_pkg::MODE_HALT;
            end else if (stopOp && !st_ff.ctrl[wdt_pd_pkg::STOP_DIS_BIT]) begin
               nxt_st.mode = wdt_pd_pkg::MODE_STOP;
               nxt_st.stopFlag = 1'b1;
            end
         end
         wdt_pd_pkg::MODE_HALT: begin
            if (coreReq.intReq) begin
               nxt_st.mode = wdt_pd_pkg::MODE_RUN;
            end
         end
         wdt_pd_pkg::MODE_STOP: begin
            if (!st_ff.wakeS2) begin
               nxt_st.mode = wdt_pd_pkg::MODE_WAKE;
            end
         end
         wdt_pd_pkg::MODE_WAKE: begin
            // start on release
            // The core restarts only once the wake line is back high.
            if (st_ff.wakeS2) begin
               nxt_st.mode = wdt_pd_pkg::MODE_RUN;
               nxt_st.vectorValid = 1'b1;
               nxt_st.stopFlag = 1'b1;
               nxt_st.ctrl[wdt_pd_pkg::STOP_DIS_BIT] = 1'b1;
            end
         end
      endcase

      if (timeout) begin
         nxt_st.wdtFlag = 1'b1;
         nxt_st.coreReset = 1'b1;
         nxt_st.vectorValid = 1'b1;
         nxt_st.mode = wdt_pd_pkg::MODE_RUN;
         nxt_st.wdtCount = initValue;
      end

      // pin ends stop
      // The pin clears the two flags, the power-down state and the prescaler, and reloads the count;
      // control settings survive.
      if (pinReset) begin
         nxt_st.wdtFlag = 1'b0;
         nxt_st.stopFlag = 1'b0;
         nxt_st.mode = wdt_pd_pkg::MODE_RUN;
         nxt_st.prescale = 6'd0;
         nxt_st.wdtCount = initValue;
         nxt_st.coreReset = 1'b1;
         nxt_st.vectorValid = 1'b1;
      end

      // Read data stand for the one cycle after the read strobe.
      nxt_st.rdata = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            wdt_pd_pkg::COUNT_A_OFS: nxt_st.rdata = st_ff.wdtCount[7:0];
            wdt_pd_pkg::COUNT_B_OFS: nxt_st.rdata = st_ff.wdtCount[15:8];
            wdt_pd_pkg::TIMER_CONTROL_HIGH_OFS: nxt_st.rdata = st_ff.ctrl;
            wdt_pd_pkg::STATUS_OFS: begin
               nxt_st.rdata[wdt_pd_pkg::WDT_FLAG_BIT] = st_ff.wdtFlag;
               nxt_st.rdata[wdt_pd_pkg::STOP_FLAG_BIT] = st_ff.stopFlag;
               nxt_st.rdata[wdt_pd_pkg::WDT_RUN_BIT] = st_ff.wdtRun;
            end
            default: nxt_st.rdata = 8'h00;
         endcase
      end

      if (!rst_n) begin
         nxt_st = '0;
         nxt_st.oscS1 = 1'b0;
         nxt_st.rstPinS1 = 1'b1;
         nxt_st.rstPinS2 = 1'b1;
         nxt_st.wakeS1 = 1'b1;
         nxt_st.wakeS2 = 1'b1;
         nxt_st.wdtCount = wdt_pd_pkg::COUNT_RESET;
         nxt_st.ctrl = wdt_pd_pkg::CTRL_RESET;
         nxt_st.wdtRun = 1'b1;
         nxt_st.firstWindow = 1'b1;
         nxt_st.mode = wdt_pd_pkg::MODE_RUN;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign regRdata = st_ff.rdata;
   assign cpuClkEn = (st_ff.mode == wdt_pd_pkg::MODE_RUN);
   assign oscEnable = (st_ff.mode != wdt_pd_pkg::MODE_STOP);
   assign coreReset = st_ff.coreReset;
   assign vectorValid = st_ff.vectorValid;
   assign vectorAddr = wdt_pd_pkg::RESTART_VECTOR;
   assign clkDiv2 = st_ff.divCnt[0];
   assign clkDiv4 = st_ff.divCnt[1];
   assign clkDiv8 = st_ff.divCnt[2];
   assign haltActive = (st_ff.mode == wdt_pd_pkg::MODE_HALT);
   assign stopActive = (st_ff.mode == wdt_pd_pkg::MODE_STOP)
                       || (st_ff.mode == wdt_pd_pkg::MODE_WAKE);

endmodule

/* File: core/wdt_pd_pkg.sv */
/*
 * Shared constants and types of the supervision timer and power-down block:
 * register offsets, field positions, reset values, opcodes and the state struct.
 * Assumes one 20 MHz reference clock and an 8-bit register port.
 */
package wdt_pd_pkg;

   // Register offsets, 8-bit register space.
   localparam logic [7:0] COUNT_A_OFS = 8'hC2;
   localparam logic [7:0] COUNT_B_OFS = 8'hC3;
   localparam logic [7:0] TIMER_CONTROL_HIGH_OFS = 8'hC1;
   localparam logic [7:0] STATUS_OFS = 8'hC4;

   // Control register fields.
   localparam int HALT_RUN_BIT = 7;
   localparam int SEL_LSB = 4;
   localparam int SEL_MSB = 6;
   localparam int STOP_DIS_BIT = 3;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hF8;
   localparam logic [7:0] CTRL_RESET = 8'hF8;

   // Status register fields.
   localparam int WDT_FLAG_BIT = 0;
   localparam int STOP_FLAG_BIT = 1;
   localparam int WDT_RUN_BIT = 2;

   // Instruction opcodes seen on the core's decode port.
   localparam logic [7:0] OP_HALT = 8'h7F;
   localparam logic [7:0] OP_STOP = 8'h6F;

   // Restart address and timing.
   localparam logic [15:0] RESTART_VECTOR = 16'h0020;
   localparam int PRESCALE_DIV = 64;
   localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE_DIV - 1);
   localparam logic [15:0] COUNT_RESET = 16'hFFFF;
   localparam logic [12:0] SEL_STEP_LOW = 13'h1FFF;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_HALT,
      MODE_STOP,
      MODE_WAKE
   } mode_t;

   typedef struct packed {
      logic oscS1;
      logic oscS2;
      logic oscS3;
      logic oscFilt;
      logic rstPinS1;
      logic rstPinS2;
      logic wakeS1;
      logic wakeS2;
      logic [2:0] divCnt;
      logic [5:0] prescale;
      logic [15:0] wdtCount;
      logic [7:0] ctrl;
      logic wdtRun;
      logic firstWindow;
      logic wdtFlag;
      logic stopFlag;
      mode_t mode;
      logic [7:0] rdata;
      logic coreReset;
      logic vectorValid;
   } state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic wdtRestart;
      logic intReq;
   } core_req_t;

endpackage

/* File: sim/wdt_power_monitor.sv */
/* Assertions on the ports of the supervision and power-down block.
   Assumes one clock and the synchronous active-low rst_n. */
`timescale 1ns/1ps
module wdt_power_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched ports
   input wire wdt_pd_pkg::core_req_t coreReq,
   input wire logic cpuClkEn,
   input wire logic coreReset,
   input wire logic vectorValid,
   input wire logic [15:0] vectorAddr,
   input wire logic oscEnable,
   input wire logic clkDiv2,
   input wire logic clkDiv4,
   input wire logic clkDiv8,
   input wire logic haltActive,
   input wire logic stopActive
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   a_halt_gates_clk: assert property (
      haltActive |-> !cpuClkEn) else $error("core clock on in halt");
   a_halt_entry: assert property (
      coreReq.valid && coreReq.opcode == 8'h7F |=> haltActive || coreReset) else $error("no halt");
   a_halt_exit: assert property (
      haltActive && coreReq.intReq |=> !haltActive) else $error("halt kept");
   a_osc_only_stop: assert property (
      !oscEnable |-> stopActive && !cpuClkEn) else $error("osc off outside stop");
   a_vector_addr: assert property (
      vectorValid |-> vectorAddr == 16'h0020 && cpuClkEn && !stopActive) else $error("bad vector");
   a_reset_vectors: assert property (
      coreReset |-> vectorValid) else $error("reset without vector");
   a_wake_vector: assert property (
      $fell(stopActive) |-> vectorValid) else $error("stop left without vector");
   a_div_chain: assert property (
      $changed(clkDiv4) |-> $fell(clkDiv2)) else $error("divider out of step");
   a_div_eight: assert property (
      $changed(clkDiv8) |-> $fell(clkDiv4)) else $error("divide by eight out of step");
   cover property (haltActive && coreReq.intReq);
   cover property ($fell(stopActive));
   cover property (coreReset);
endmodule

/* File: sim/core_model.sv */
/* Core model: turns bench requests into one-cycle decode pulses.
   Assumes the block gates the core clock through cpuClkEn. */
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Bench side
   input wire logic issue,
   input wire logic [7:0] opIn,
   input wire logic restartIn,
   input wire logic intIn,
   // Block side
   input wire logic cpuClkEn,
   output wdt_pd_pkg::core_req_t coreReq
);
   // gated core stalls
   // A gated core fetches nothing, so a request made then is lost.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         coreReq <= '0;
      end else begin
         coreReq.intReq <= intIn;
         coreReq.valid <= issue && cpuClkEn;
         coreReq.opcode <= issue ? opIn : ~coreReq.opcode;
         coreReq.wdtRestart <= issue && restartIn;
      end
   end
endmodule

/* File: sim/tb_top.sv */
/* Bench top: core model, register cycles, gated oscillator, wake and reset pins.
   Assumes the design package and the bench modules are compiled first. */
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic oscillatorOutputPin = 1'b0;
   logic resetPin_n = 1'b1;
   logic portBLineZero = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic issue = 1'b0;
   logic [7:0] opIn = 8'h00;
   logic restartIn = 1'b0;
   logic intIn = 1'b0;
   wdt_pd_pkg::core_req_t coreReq;
   logic [7:0] regRdata, v;
   logic cpuClkEn, coreReset, vectorValid, oscEnable, clkDiv2, clkDiv4, haltActive, stopActive;
   logic [15:0] vectorAddr;
   int n_errors = 0;
   int checked = 0;
   int i;
   wdt_power_ctrl dut (.ref_clk, .rst_n, .oscillatorOutputPin, .resetPin_n, .portBLineZero,
      .coreReq, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .cpuClkEn, .coreReset,
      .vectorValid, .vectorAddr, .oscEnable, .clkDiv2, .clkDiv4, .clkDiv8(), .haltActive,
      .stopActive);
   core_model core (.ref_clk, .rst_n, .issue, .opIn, .restartIn, .intIn, .cpuClkEn, .coreReq);
   always #25 ref_clk = ~ref_clk;
   // The crystal stands still while the block has switched it off.
   always begin
      repeat (3) @(posedge ref_clk);
      if (oscEnable === 1'b1) oscillatorOutputPin <= ~oscillatorOutputPin;
   end
   ////////////////////////////////////////
   task automatic close_out;
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bnd(input logic ok);
      chk(16'(ok), 16'h0001);
      if (ok !== 1'b1) close_out;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 chk(16'(regRdata), 16'(e));
   endtask
   task automatic ex(input logic [7:0] op, input logic rs);
      @(posedge ref_clk);
      issue <= 1'b1;
      opIn <= op;
      restartIn <= rs;
      @(posedge ref_clk);
      issue <= 1'b0;
   endtask
   ////////////////////////////////////////
   initial begin
      v = 8'($urandom(32'h92f3));
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'hC1, 8'hF8);
      rd(8'hC4, 8'h04);
      rd(8'hC3, 8'hFF);
      rd(8'h00, 8'h00);
      for (int s = 0; s < 8; s++) begin
         v = 8'($urandom);
         wr(8'hC1, {1'b1, 3'(s), v[3:0]});
         rd(8'hC1, {1'b1, 3'(s), v[3], 3'h0});
         ex({1'b1, v[6:0]}, 1'b1);
         rd(8'hC3, {3'(s), 5'h1F});
      end
      wr(8'hC4, 8'h00);
      rd(8'hC4, 8'h04);
      wr(8'hC1, 8'hF8);
      ex(8'h6F, 1'b0);
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(stopActive), 16'h0000);
      ex(8'h7F, 1'b0);
      #1;
      for (i = 0; i < 9 && !haltActive; i++) #50;
      bnd(haltActive);
      chk(16'(cpuClkEn), 16'h0000);
      @(posedge ref_clk) intIn <= 1'b1;
      #1;
      for (i = 0; i < 9 && haltActive; i++) #50;
      bnd(!haltActive);
      @(posedge ref_clk) intIn <= 1'b0;
      wr(8'hC1, 8'hF0);
      ex(8'h6F, 1'b0);
      #1;
      for (i = 0; i < 9 && !stopActive; i++) #50;
      bnd(stopActive);
      chk(16'(oscEnable), 16'h0000);
      @(posedge ref_clk) portBLineZero <= 1'b0;
      #1;
      for (i = 0; i < 9 && !oscEnable; i++) #50;
      bnd(oscEnable);
      for (i = 0; i < 6; i++) #50 chk(16'(vectorValid), 16'h0000);
      @(posedge ref_clk) portBLineZero <= 1'b1;
      #1;
      for (i = 0; i < 9 && !vectorValid; i++) #50;
      bnd(vectorValid);
      rd(8'hC1, 8'hF8);
      rd(8'hC4, 8'h06);
      wr(8'hC3, 8'h00);
      wr(8'hC2, 8'h01);
      ex(8'h7F, 1'b0);
      #1;
      for (i = 0; i < 1000 && !coreReset; i++) #50;
      bnd(coreReset);
      chk(16'(haltActive), 16'h0000);
      rd(8'hC4, 8'h07);
      rd(8'hC4, 8'h07);
      wr(8'hC4, 8'hFE);
      rd(8'hC4, 8'h06);
      @(posedge ref_clk) resetPin_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      resetPin_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(8'hC4, 8'h04);
      rd(8'hC1, 8'hF8);
      close_out;
   end
endmodule

bind wdt_power_ctrl wdt_power_monitor mon (.ref_clk, .rst_n, .coreReq, .cpuClkEn, .coreReset,
   .vectorValid, .vectorAddr, .oscEnable, .clkDiv2, .clkDiv4, .clkDiv8, .haltActive,
   .stopActive);
